// ===== hdl/status_pkg.sv
package status_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses, APB)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  ADDR_STATUS    = 8'h00;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h08;
  localparam logic [7:0]  ADDR_PAGE_BASE = 8'h0C;

  // ---------------------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------------------
  localparam int          STATUS_WIDTH   = 8;
  localparam int          BIT_PAGE_HIGH  = 7;
  localparam int          BIT_PAGE_MID   = 6;
  localparam int          BIT_PAGE_LOW   = 5;
  localparam int          BIT_SECOND_TIMER_OVF   = 4;
  localparam int          BIT_IRQ_OFF    = 3;
  localparam int          BIT_ZERO       = 2;
  localparam int          BIT_DCARRY     = 1;
  localparam int          BIT_CARRY      = 0;
  localparam logic [7:0]  STATUS_RESET   = 8'h08;
  localparam logic [7:0]  ARITH_MASK     = 8'h07;

  // ---------------------------------------------------------------------------
  // Program pages
  // ---------------------------------------------------------------------------
  localparam int          PAGE_WORDS     = 512;
  localparam int          PC_WIDTH       = 11;
  localparam logic [10:0] PAGE0_BASE     = 11'h000;
  localparam logic [10:0] PAGE1_BASE     = 11'h200;
  localparam logic [10:0] PAGE2_BASE     = 11'h400;
  localparam logic [10:0] PAGE3_BASE     = 11'h600;

  // ---------------------------------------------------------------------------
  // Interrupt event bits
  // ---------------------------------------------------------------------------
  localparam int          EVT_WIDTH      = 3;
  localparam int          EVT_SECOND_TIMER       = 0;
  localparam int          EVT_ZERO       = 1;
  localparam int          EVT_CARRY      = 2;
  localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;

  // ---------------------------------------------------------------------------
  // Core operations
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_ADD    = 3'h1,
    OP_SUB    = 3'h2,
    OP_LOGIC  = 3'h3,
    OP_MOVE   = 3'h4,
    OP_BITSET = 3'h5,
    OP_BITCLR = 3'h6
  } core_op_t;

  typedef struct packed {
    logic       valid;
    core_op_t   op;
    logic [7:0] w_val;
    logic [7:0] f_val;
    logic       dest_status;
    logic [2:0] bit_sel;
  } core_req_t;

  typedef struct packed {
    logic       zero;
    logic       dcarry;
    logic       carry;
    logic       upd_zero;
    logic       upd_dcarry;
    logic       upd_carry;
    logic [7:0] result;
  } alu_res_t;

endpackage : status_pkg

// ===== hdl/status_alu.sv
`timescale 1ns/1ps
module status_alu
  import status_pkg::*;
(
  input  status_pkg::core_req_t req,
  output status_pkg::alu_res_t  res
);
  always_comb
  begin
    logic [4:0] low_sum;
    logic [8:0] full_sum;
    low_sum  = 5'h00;
    full_sum = 9'h000;
    res      = '0;
    case (req.op)
      OP_ADD:
      begin
        low_sum        = {1'b0, req.f_val[3:0]} + {1'b0, req.w_val[3:0]};
        full_sum       = {1'b0, req.f_val} + {1'b0, req.w_val};
        res.result     = full_sum[7:0];
        res.carry      = full_sum[8];
        res.dcarry     = low_sum[4];
        res.zero       = (full_sum[7:0] == 8'h00);
        res.upd_zero   = 1'b1;
        res.upd_dcarry = 1'b1;
        res.upd_carry  = 1'b1;
      end
      OP_SUB:
      begin
        // Two's complement add: carry out means no borrow
        low_sum        = {1'b0, req.f_val[3:0]} + {1'b0, ~req.w_val[3:0]} + 5'h01;
        full_sum       = {1'b0, req.f_val} + {1'b0, ~req.w_val} + 9'h001;
        res.result     = full_sum[7:0];
        res.carry      = full_sum[8];
        res.dcarry     = low_sum[4];
        res.zero       = (full_sum[7:0] == 8'h00);
        res.upd_zero   = 1'b1;
        res.upd_dcarry = 1'b1;
        res.upd_carry  = 1'b1;
      end
      OP_LOGIC:
      begin
        res.result   = req.f_val & req.w_val;
        res.zero     = (res.result == 8'h00);
        res.upd_zero = 1'b1;
      end
      OP_MOVE:
        res.result = req.w_val;
      OP_BITSET:
        res.result = req.f_val | (8'h01 << req.bit_sel);
      OP_BITCLR:
        res.result = req.f_val & ~(8'h01 << req.bit_sel);
      default:
        res.result = req.f_val;
    endcase
  end
endmodule : status_alu

// ===== hdl/cpu_status_flags_register.sv
`timescale 1ns/1ps
// Operation
// - Status accepts any instruction result as destination
// - Arithmetic flag writes blocked when ALU sets them
// - Eight bits: page, timer, irq-off, Z DC C
// - Low two page bits pick fetch page
// - Top page bit only stores, no effect
// - Timer B flag set on overflow, cleared
// - Irq-off one blocks, zero permits interrupts
// - Zero flag follows zero result of add/sub/logic
// - Digit carry from add/sub only
// - Carry out on add, no-borrow on subtract
module cpu_status_flags_register
  import status_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  status_pkg::core_req_t     core_req,
  input  wire logic                 second_timer_overflow,
  input  wire logic                 irq_request,
  output logic [7:0]                core_result_ff,
  output logic [7:0]                status_ff,
  output logic [10:0]               page_base_ff,
  output logic                      irq_enable_ff,
  output logic                      irq_ff
);
  import status_pkg::*;

  // ---------------------------------------------------------------------------
  // Arithmetic unit
  // ---------------------------------------------------------------------------
  alu_res_t alu_res;

  status_alu u_alu (
    .req (core_req),
    .res (alu_res)
  );

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  logic apb_setup;
  logic apb_wr;
  logic apb_rd;
  logic wr_status;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic core_exec;

  assign apb_setup   = psel && !penable;
  assign apb_wr      = psel && penable && pready && pwrite;
  assign apb_rd      = psel && !penable && !pwrite;
  assign wr_status   = apb_wr && (paddr == ADDR_STATUS);
  assign wr_irq_stat = apb_wr && (paddr == ADDR_IRQ_STAT);
  assign wr_irq_mask = apb_wr && (paddr == ADDR_IRQ_MASK);
  assign core_exec   = core_req.valid;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ADDR_STATUS) || (a == ADDR_IRQ_STAT) ||
                  (a == ADDR_IRQ_MASK) || (a == ADDR_PAGE_BASE);
  endfunction : addr_mapped

  function automatic logic [10:0] page_base(input logic [1:0] sel);
    case (sel)
      2'h0:    page_base = PAGE0_BASE;
      2'h1:    page_base = PAGE1_BASE;
      2'h2:    page_base = PAGE2_BASE;
      default: page_base = PAGE3_BASE;
    endcase
  endfunction : page_base

  // One wait-free access phase
  always_ff @(posedge clock)
  begin
    if (srst)
      pready <= 1'b0;
    else
      pready <= apb_setup;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      pslverr <= 1'b0;
    else if (apb_setup)
      pslverr <= !addr_mapped(paddr);
    else
      pslverr <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------------------
  logic [7:0] nxt_status;
  logic       core_dest;

  assign core_dest = core_exec && core_req.dest_status;

  always_comb
  begin
    nxt_status = status_ff;
    if (core_dest)
      nxt_status = alu_res.result;
    else if (wr_status)
      nxt_status = pwdata[7:0];
    // Flag bits keep their value when the op owns a flag
    if (core_dest && (alu_res.upd_zero || alu_res.upd_dcarry || alu_res.upd_carry))
      nxt_status[BIT_ZERO:BIT_CARRY] = status_ff[BIT_ZERO:BIT_CARRY];
    if (core_exec && alu_res.upd_zero)
      nxt_status[BIT_ZERO] = alu_res.zero;
    else if (core_dest && !wr_status)
      nxt_status[BIT_ZERO] = alu_res.result[BIT_ZERO];
    if (core_exec && alu_res.upd_dcarry)
      nxt_status[BIT_DCARRY] = alu_res.dcarry;
    if (core_exec && alu_res.upd_carry)
      nxt_status[BIT_CARRY] = alu_res.carry;
    if (second_timer_overflow)
      nxt_status[BIT_SECOND_TIMER_OVF] = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      status_ff <= STATUS_RESET;
    else
      status_ff <= nxt_status;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      core_result_ff <= 8'h00;
    else if (core_exec)
      core_result_ff <= alu_res.result;
  end

  // ---------------------------------------------------------------------------
  // Page select and global interrupt gate
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      page_base_ff <= PAGE0_BASE;
    else
      page_base_ff <= page_base(nxt_status[BIT_PAGE_LOW +: 2]);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      irq_enable_ff <= 1'b0;
    else
      irq_enable_ff <= irq_request && !nxt_status[BIT_IRQ_OFF];
  end

  // ---------------------------------------------------------------------------
  // Event interrupts
  // ---------------------------------------------------------------------------
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic [2:0] evt;
  logic [2:0] nxt_irq_stat;

  assign evt[EVT_SECOND_TIMER]  = second_timer_overflow;
  assign evt[EVT_ZERO]  = core_exec && alu_res.upd_zero && alu_res.zero;
  assign evt[EVT_CARRY] = core_exec && alu_res.upd_carry && alu_res.carry;

  // Set wins over write-one-to-clear
  assign nxt_irq_stat = (irq_stat_ff & ~(wr_irq_stat ? pwdata[2:0] : 3'h0)) | evt;

  always_ff @(posedge clock)
  begin
    if (srst)
      irq_stat_ff <= 3'h0;
    else
      irq_stat_ff <= nxt_irq_stat;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      irq_mask_ff <= IRQ_MASK_RESET;
    else if (wr_irq_mask)
      irq_mask_ff <= pwdata[2:0];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      prdata <= 32'h00000000;
    else if (apb_rd)
    begin
      case (paddr)
        ADDR_STATUS:    prdata <= {24'h000000, status_ff};
        ADDR_IRQ_STAT:  prdata <= {29'h00000000, irq_stat_ff};
        ADDR_IRQ_MASK:  prdata <= {29'h00000000, irq_mask_ff};
        ADDR_PAGE_BASE: prdata <= {21'h000000, page_base_ff};
        default:        prdata <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_add_carry;
    @(posedge clock) disable iff (srst)
    (core_exec && core_req.op == OP_ADD) |=> status_ff[BIT_CARRY] ==
      (({1'b0, $past(core_req.f_val)} + {1'b0, $past(core_req.w_val)}) > 9'h0FF);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("carry wrong after add");

  property p_zero_flag;
    @(posedge clock) disable iff (srst)
    (core_exec && alu_res.upd_zero) |=> status_ff[BIT_ZERO] == ($past(alu_res.result) == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag mismatch");

  property p_dc_keep;
    @(posedge clock) disable iff (srst)
    (core_exec && core_req.op == OP_LOGIC && !core_req.dest_status && !wr_status)
      |=> $stable(status_ff[BIT_DCARRY]) && $stable(status_ff[BIT_CARRY]);
  endproperty
  a_dc_keep: assert property (p_dc_keep) else $error("flags changed by logic op");

  property p_block;
    @(posedge clock) disable iff (srst)
    (wr_status && !core_exec) |=> status_ff ==
      ($past(pwdata[7:0]) | {3'h0, $past(second_timer_overflow), 4'h0});
  endproperty
  a_block: assert property (p_block) else $error("status write lost");

  property p_arith_block;
    @(posedge clock) disable iff (srst)
    (core_dest && core_req.op == OP_SUB) |=>
      status_ff[BIT_CARRY] == ($past(core_req.f_val) >= $past(core_req.w_val));
  endproperty
  a_arith_block: assert property (p_arith_block) else $error("flag write not blocked");

  property p_page;
    @(posedge clock) disable iff (srst)
    1'b1 |=> page_base_ff == page_base(status_ff[BIT_PAGE_LOW +: 2]);
  endproperty
  a_page: assert property (p_page) else $error("page base mismatch");

  property p_second_timer;
    @(posedge clock) disable iff (srst)
    second_timer_overflow |=> status_ff[BIT_SECOND_TIMER_OVF] && irq_stat_ff[EVT_SECOND_TIMER];
  endproperty
  a_second_timer: assert property (p_second_timer) else $error("timer flag not set");

  property p_irq_off;
    @(posedge clock) disable iff (srst)
    status_ff[BIT_IRQ_OFF] && $past(status_ff[BIT_IRQ_OFF]) |-> !irq_enable_ff;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt passed while off");

  property p_dc_add;
    @(posedge clock) disable iff (srst)
    (core_exec && core_req.op == OP_ADD) |=> status_ff[BIT_DCARRY] ==
      (({1'b0, $past(core_req.f_val[3:0])} + {1'b0, $past(core_req.w_val[3:0])}) > 5'h0F);
  endproperty
  a_dc_add: assert property (p_dc_add) else $error("digit carry wrong after add");

  property p_sub_carry;
    @(posedge clock) disable iff (srst)
    (core_exec && core_req.op == OP_SUB) |=>
      status_ff[BIT_CARRY] == ($past(core_req.f_val) >= $past(core_req.w_val));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("carry wrong after subtract");

  property p_zero_add;
    @(posedge clock) disable iff (srst)
    (core_exec && core_req.op == OP_ADD) |=>
      status_ff[BIT_ZERO] == (8'($past(core_req.f_val) + $past(core_req.w_val)) == 8'h00);
  endproperty
  a_zero_add: assert property (p_zero_add) else $error("zero flag wrong after add");

  property p_logic_keep;
    @(posedge clock) disable iff (srst)
    (core_dest && core_req.op == OP_LOGIC) |=> $stable(status_ff[BIT_DCARRY -: 2]);
  endproperty
  a_logic_keep: assert property (p_logic_keep) else $error("logic op wrote flags");

  property p_zero_hold;
    @(posedge clock) disable iff (srst)
    (!wr_status && !core_dest && !(core_exec && core_req.op inside {OP_ADD, OP_SUB, OP_LOGIC}))
      |=> $stable(status_ff[BIT_ZERO]);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero flag changed");

  property p_dc_c_hold;
    @(posedge clock) disable iff (srst)
    (!wr_status && !core_dest && !(core_exec && core_req.op inside {OP_ADD, OP_SUB}))
      |=> $stable(status_ff[BIT_DCARRY -: 2]);
  endproperty
  a_dc_c_hold: assert property (p_dc_c_hold) else $error("carry flags changed");

  property p_move_dest;
    @(posedge clock) disable iff (srst)
    (core_dest && core_req.op == OP_MOVE && !second_timer_overflow)
      |=> status_ff == $past(core_req.w_val);
  endproperty
  a_move_dest: assert property (p_move_dest) else $error("move to status lost");

  property p_status_reset;
    @(posedge clock)
    srst |=> (status_ff == STATUS_RESET) && !irq_ff && !pready;
  endproperty
  a_status_reset: assert property (p_status_reset) else $error("reset value wrong");

  property p_timer_hold;
    @(posedge clock) disable iff (srst)
    (status_ff[BIT_SECOND_TIMER_OVF] && !wr_status && !core_dest) |=> status_ff[BIT_SECOND_TIMER_OVF];
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("timer flag dropped");

  property p_top_store;
    @(posedge clock) disable iff (srst)
    (wr_status && !core_dest) |=> status_ff[BIT_PAGE_HIGH] == $past(pwdata[BIT_PAGE_HIGH]);
  endproperty
  a_top_store: assert property (p_top_store) else $error("top page bit not stored");

  property p_irq_on;
    @(posedge clock) disable iff (srst)
    (irq_request && !status_ff[BIT_IRQ_OFF] && !wr_status && !core_dest) |=> irq_enable_ff;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt held while on");

endmodule : cpu_status_flags_register

// ===== dv/core_model.sv
`timescale 1ns/1ps
module core_model
  import status_pkg::*;
(
  input  wire logic             clock,
  output status_pkg::core_req_t core_req
);
  import status_pkg::*;

  initial core_req = '0;

  // Status as destination only as the caller asks
  task automatic issue(input core_op_t op, input logic [7:0] w, input logic [7:0] f,
                       input logic dest, input logic [2:0] b);
    @(posedge clock);
    core_req <= '{1'b1, op, w, f, dest, b};
    @(posedge clock);
    core_req.valid <= 1'b0;
  endtask : issue
endmodule : core_model

// ===== dv/test_cpu_status_flags_register.sv
`timescale 1ns/1ps
module test_cpu_status_flags_register;
  import status_pkg::*;
  logic        clock, srst, psel, penable, pwrite, second_timer_overflow, irq_request;
  logic        pready, pslverr, irq_enable_ff, irq_ff, er, d;
  logic [7:0]  paddr, core_result_ff, status_ff, exp_st, w, f, res;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] page_base_ff;
  logic [2:0]  b;
  core_op_t    op;
  core_req_t   core_req;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          seed = 2;

  cpu_status_flags_register dut_u (.clock(clock), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_req(core_req), .second_timer_overflow(second_timer_overflow),
    .irq_request(irq_request), .core_result_ff(core_result_ff), .status_ff(status_ff),
    .page_base_ff(page_base_ff), .irq_enable_ff(irq_enable_ff), .irq_ff(irq_ff));
  core_model u_core (.clock(clock), .core_req(core_req));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= dat;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] alu_exp(input core_op_t o, input logic [7:0] wv, fv, s,
                                         input logic ds, input logic [2:0] bs,
                                         output logic [7:0] rs);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] n;
    n = s;
    h = 5'h0;
    case (o)
      OP_ADD:    begin r = fv + wv; h = fv[3:0] + wv[3:0]; end
      OP_SUB:    begin r = fv + {1'b0, ~wv} + 9'h1; h = fv[3:0] + {1'b0, ~wv[3:0]} + 5'h1; end
      OP_LOGIC:  r = {1'b0, fv & wv};
      OP_MOVE:   r = {1'b0, wv};
      OP_BITSET: r = {1'b0, fv | (8'h01 << bs)};
      default:   r = {1'b0, fv & ~(8'h01 << bs)};
    endcase
    rs = r[7:0];
    if (ds)
      n = (o inside {OP_ADD, OP_SUB, OP_LOGIC}) ? {r[7:3], s[2:0]} : r[7:0];
    if (o inside {OP_ADD, OP_SUB, OP_LOGIC})
      n[BIT_ZERO] = (r[7:0] == 8'h00);
    if (o inside {OP_ADD, OP_SUB})
    begin
      n[BIT_DCARRY] = h[4];
      n[BIT_CARRY]  = r[8];
    end
    return n;
  endfunction : alu_exp

  task automatic stop_test;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    second_timer_overflow = 1'b0;
    irq_request = 1'b0;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1 check("status_reset", status_ff, STATUS_RESET);
    check("page_reset", page_base_ff, 11'h000);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status_read", rd, {24'h0, STATUS_RESET});
    for (int i = 0; i < 8; i++)
    begin
      exp_st = {i[2:0], 2'b01, 3'($random(seed))};
      apb(1'b1, ADDR_STATUS, {24'h0, exp_st});
      #1 check("status_write", status_ff, exp_st);
      @(posedge clock);
      #1 check("page_base", page_base_ff, {i[1:0], 9'h000});
      apb(1'b0, ADDR_PAGE_BASE, 32'h0);
      check("page_read", rd, {21'h0, i[1:0], 9'h000});
    end
    for (int i = 0; i < 46; i++)
    begin
      w  = $random(seed);
      f  = $random(seed);
      b  = $random(seed);
      op = core_op_t'(1 + (i % 6));
      d  = (i % 5 == 3);
      if (i < 4)
      begin
        op = (i < 2) ? OP_ADD : OP_SUB;
        d  = 1'b0;
        {w, f} = (i == 0) ? 16'h0808 : (i == 1) ? 16'h01FF : (i == 2) ? 16'h5555 : 16'h0110;
      end
      if (d)
        f = exp_st;
      u_core.issue(op, w, f, d, b);
      exp_st = alu_exp(op, w, f, exp_st, d, b, res);
      #1 check("status_op", status_ff, exp_st);
      check("result", core_result_ff, res);
    end
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    check("irq_events", rd, (32'h1 << EVT_ZERO) | (32'h1 << EVT_CARRY));
    apb(1'b1, ADDR_IRQ_STAT, 32'h7);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1 << EVT_SECOND_TIMER);
    #1 check("irq_idle", irq_ff, 1'b0);
    @(posedge clock);
    second_timer_overflow <= 1'b1;
    irq_request <= 1'b1;
    @(posedge clock);
    second_timer_overflow <= 1'b0;
    repeat (3) @(posedge clock);
    #1 check("timer_flag", status_ff, 8'h10);
    check("irq_on", irq_enable_ff, 1'b1);
    check("irq_line", irq_ff, 1'b1);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clock);
    #1 check("irq_masked", irq_ff, 1'b0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    apb(1'b0, ADDR_IRQ_MASK, 32'h0);
    check("mask_read", rd, 32'h1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clock);
    #1 check("irq_cleared", irq_ff, 1'b0);
    apb(1'b1, ADDR_STATUS, 32'h08);
    #1 check("timer_clear", status_ff, 8'h08);
    repeat (2) @(posedge clock);
    #1 check("irq_off", irq_enable_ff, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped_err", er, 1'b1);
    check("unmapped_data", rd, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'hF7);
    #1 check("page_top", page_base_ff, PAGE3_BASE);
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    #1 check("status_rst2", status_ff, STATUS_RESET);
    check("page_rst2", page_base_ff, PAGE0_BASE);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status_rd2", rd, {24'h0, STATUS_RESET});
    stop_test();
  end
endmodule : test_cpu_status_flags_register
